/* sld_pkg.sv */
// Purpose: Shared constants for the serial-in latched driver controller
// Assumes: One 20 MHz system clock, asynchronous active-low reset
// Notes:   Shift pins arrive from another domain and are synchronised
package sld_pkg;
    localparam int          SLD_STAGES     = 20;
    localparam int          SLD_FIFO_DEPTH = 8;
    localparam int          SLD_FIFO_WIDTH = 1;
    localparam logic [19:0] SLD_SHIFT_RST  = 20'h00000;
    localparam logic [19:0] SLD_LATCH_RST  = 20'h00000;
    localparam logic [19:0] SLD_ALL_ON     = 20'hFFFFF;

    typedef enum logic [2:0] {
        SLD_IDLE  = 3'h1,
        SLD_SHIFT = 3'h2,
        SLD_HOLD  = 3'h4
    } sld_phase_t;
endpackage : sld_pkg

/* sld_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, clock enable freezes all state
// Notes:   Full and empty are exact; depth must be a power of two
`timescale 1ns/10ps
module sld_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,    // System clock
    input  wire logic             rst_b,    // Async reset, active low
    input  wire logic             clk_en,   // Clock enable
    input  wire logic             in_valid, // Write request
    output logic                  in_ready, // Not full
    input  wire logic [WIDTH-1:0] in_data,  // Write data
    output logic                  out_valid,// Not empty
    input  wire logic             out_ready,// Read accept
    output logic      [WIDTH-1:0] out_data  // Head word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } sld_fifo_st_t;

    sld_fifo_st_t st_q;
    sld_fifo_st_t st_d;
    logic         do_wr;
    logic         do_rd;

    assign in_ready  = (st_q.wr - st_q.rd) != (AW+1)'(DEPTH);
    assign out_valid = st_q.wr != st_q.rd;
    assign out_data  = st_q.mem[st_q.rd[AW-1:0]];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always_comb begin
        st_d = st_q;
        if (do_wr) begin
            st_d.mem[st_q.wr[AW-1:0]] = in_data;
            st_d.wr = st_q.wr + (AW+1)'(1);
        end
        if (do_rd) begin
            st_d.rd = st_q.rd + (AW+1)'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end
endmodule : sld_fifo

/* sld_driver.sv */
// Purpose: 20-stage serial-in shift register, transparent latches and blanking
// Assumes: Shift clock, data, load and blank are pins sampled on a 20 MHz clock
// Notes:   Serial bits queue in a FIFO; shift stalls while load is high
//
// Function
// - The block holds 20 shift stages, each with a latch and an output driver.
// - On a rising shift clock edge the serial data level enters the first stage.
// - On each such edge every stage moves its bit one place toward the serial output; here a shift waits for load low, and an edge on a full queue is lost.
// - While latch load is high every latch follows its shift stage.
// - While blank is high all source drives are off and all pull-downs are on.
// - Blank never alters the latch contents.
// - While blank is low each output follows its own latch.
// - The last shift stage is presented on the serial data output.
`timescale 1ns/10ps
module sld_driver
    import sld_pkg::*;
(
    input  wire logic                  clock,      // System clock, 20 MHz
    input  wire logic                  rst_b,      // Async reset, active low
    input  wire logic                  clk_en,     // Clock enable, freezes state
    input  wire logic                  shift_clk,  // Serial shift clock pin
    input  wire logic                  ser_in,     // Serial data input pin
    input  wire logic                  latch_load, // Latch load pin, high = transparent
    input  wire logic                  blank,      // Blank pin, high = outputs off
    output logic                       ser_out,    // Serial data output
    output logic     [SLD_STAGES-1:0]  src_on,     // Source driver enables
    output logic     [SLD_STAGES-1:0]  pull_on,    // Pull-down sink enables
    output logic                       overrun     // Edge hit a full bit queue, its bit was lost
);
    typedef struct packed {
        logic [1:0]            sck_s;
        logic [1:0]            sdi_s;
        logic [1:0]            ld_s;
        logic [1:0]            blk_s;
        logic                  sck_prev;
        logic [SLD_STAGES-1:0] shreg;
        logic [SLD_STAGES-1:0] latch;
        logic [SLD_STAGES-1:0] src;
        logic [SLD_STAGES-1:0] pull;
        logic                  ovr;
        sld_phase_t            phase;
    } sld_st_t;

    sld_st_t st_q;
    sld_st_t st_d;
    logic    rise;
    logic    q_ready;
    logic    q_valid;
    logic    q_bit;
    logic    take;

    assign rise = st_q.sck_s[1] && !st_q.sck_prev;
    // Bits are applied only while the latches are closed, so a held
    // load level sees a stable register between applied shifts
    assign take = q_valid && !st_q.ld_s[1];

    sld_fifo #(
        .WIDTH (SLD_FIFO_WIDTH),
        .DEPTH (SLD_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_valid  (rise),
        .in_ready  (q_ready),
        .in_data   (st_q.sdi_s[1]),
        .out_valid (q_valid),
        .out_ready (take),
        .out_data  (q_bit)
    );

    always_comb begin
        st_d          = st_q;
        st_d.sck_s    = {st_q.sck_s[0], shift_clk};
        st_d.sdi_s    = {st_q.sdi_s[0], ser_in};
        st_d.ld_s     = {st_q.ld_s[0], latch_load};
        st_d.blk_s    = {st_q.blk_s[0], blank};
        st_d.sck_prev = st_q.sck_s[1];
        st_d.ovr      = rise && !q_ready;
        // Queued bits only; an empty queue or a high load leaves the register alone
        if (take) begin
            st_d.shreg = {st_q.shreg[SLD_STAGES-2:0], q_bit};
        end
        if (st_q.ld_s[1]) begin
            st_d.latch = st_q.shreg;
        end
        if (st_q.blk_s[1]) begin
            st_d.src  = '0;
            st_d.pull = SLD_ALL_ON;
        end else begin
            st_d.src  = st_d.latch;
            st_d.pull = ~st_d.latch;
        end
        case (st_q.phase)
            SLD_IDLE:  st_d.phase = q_valid ? SLD_SHIFT : SLD_IDLE;
            SLD_SHIFT: st_d.phase = st_q.ld_s[1] ? SLD_HOLD
                                  : (q_valid ? SLD_SHIFT : SLD_IDLE);
            SLD_HOLD:  st_d.phase = st_q.ld_s[1] ? SLD_HOLD : SLD_IDLE;
            default:   st_d.phase = SLD_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q       <= '0;
            st_q.shreg <= SLD_SHIFT_RST;
            st_q.latch <= SLD_LATCH_RST;
            st_q.pull  <= SLD_ALL_ON;
            st_q.phase <= SLD_IDLE;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign ser_out = st_q.shreg[SLD_STAGES-1];
    assign src_on  = st_q.src;
    assign pull_on = st_q.pull;
    assign overrun = st_q.ovr;
endmodule : sld_driver

/* sld_driver_props.sv */
// Purpose: Output checks for sld_driver
// Assumes: clk_en high
// Notes:   quiet_q counts idle pin cycles
`timescale 1ns/10ps
module sld_driver_props
    import sld_pkg::*;
(
    input wire logic                  clock,      // Clock
    input wire logic                  rst_b,      // Reset
    input wire logic                  clk_en,     // Enable
    input wire logic                  shift_clk,  // Shift pin
    input wire logic                  ser_in,     // Data pin
    input wire logic                  latch_load, // Load pin
    input wire logic                  blank,      // Blank pin
    input wire logic                  ser_out,    // Serial out
    input wire logic [SLD_STAGES-1:0] src_on,     // Sources
    input wire logic [SLD_STAGES-1:0] pull_on,    // Pull-downs
    input wire logic                  overrun     // Lost bit
);
    logic [3:0] quiet_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) quiet_q <= 4'h0;
        else if (shift_clk || latch_load || $changed(blank)) quiet_q <= 4'h0;
        else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end
    blank_src_a: assert property (blank [*4] |-> src_on == '0) else $error("src on");
    blank_pull_a: assert property (blank [*4] |-> pull_on == SLD_ALL_ON) else $error("pull");
    drive_comp_a: assert property ((src_on ^ pull_on) == SLD_ALL_ON) else $error("comp");
    ser_hold_a: assert property (quiet_q == 4'hF |-> $stable(ser_out)) else $error("ser");
    latch_hold_a: assert property (quiet_q == 4'hF |-> $stable(src_on)) else $error("src");
    pull_hold_a: assert property (quiet_q == 4'hF |-> $stable(pull_on)) else $error("pl");
    load_follow_a: assert property ((latch_load && !blank) [*6] |->
        src_on[SLD_STAGES-1] == ser_out) else $error("follow");
    load_stall_a: assert property (latch_load [*5] |-> $stable(ser_out)) else $error("stall");
    cover property (blank [*4]);
    cover property (latch_load [*6]);
    cover property (overrun);
endmodule : sld_driver_props
bind sld_driver sld_driver_props i_sld_driver_props (.clock(clock), .rst_b(rst_b),
    .clk_en(clk_en), .shift_clk(shift_clk), .ser_in(ser_in), .latch_load(latch_load),
    .blank(blank), .ser_out(ser_out), .src_on(src_on), .pull_on(pull_on), .overrun(overrun));

/* sld_host.sv */
// Purpose: Host model for the driver pins
// Assumes: Pins move 2 ns after a clock edge
// Notes:   Data pin inverts once its hold ends
`timescale 1ns/10ps
module sld_host (
    input  wire logic clock,      // Clock
    output logic      shift_clk,  // Shift pin
    output logic      ser_in,     // Data pin
    output logic      latch_load, // Load pin
    output logic      blank       // Blank pin
);
    initial begin
        shift_clk = 1'b0;
        ser_in = 1'b0;
        latch_load = 1'b0;
        blank = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick
    task automatic send_bit(input logic b);
        ser_in = b;
        tick(3);
        shift_clk = 1'b1;
        tick(3);
        shift_clk = 1'b0;
        tick(3);
        ser_in = ~b;
    endtask : send_bit
    task automatic pins(input logic load, input logic blk);
        latch_load = load;
        blank = blk;
        tick(6);
    endtask : pins
endmodule : sld_host

/* tb_sld_driver.sv */
// Purpose: Self-checking bench for sld_driver
// Assumes: clk_en high except for the final frozen-block section
// Notes:   sr_m and lat_m model stages and latches
`timescale 1ns/10ps
module tb_sld_driver;
    import sld_pkg::*;
    logic                  clock, rst_b, sck, sdi, load, blk, ser_out, overrun, en;
    logic [SLD_STAGES-1:0] src_on, pull_on, sr_m, lat_m;
    logic [SLD_STAGES:0]   exp_q[$];
    int                    num_errors, check_count, cyc, ovr;
    event                  chk;
    sld_host i_sld_host (.clock(clock), .shift_clk(sck), .ser_in(sdi), .latch_load(load),
        .blank(blk));
    sld_driver i_sld_driver (.clock(clock), .rst_b(rst_b), .clk_en(en), .shift_clk(sck),
        .ser_in(sdi), .latch_load(load), .blank(blk), .ser_out(ser_out), .src_on(src_on),
        .pull_on(pull_on), .overrun(overrun));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        ovr <= ovr + overrun;
        if (cyc == 4000) begin
            num_errors++;
            summarize();
        end
    end
    always @(chk) begin
        check_count++;
        if ({ser_out, src_on} !== exp_q.pop_front()) begin
            num_errors++;
            $display("unexpected at %0t: output mismatch", $time);
        end
    end
    task automatic expect_out(input logic [SLD_STAGES-1:0] v);
        exp_q.push_back({sr_m[SLD_STAGES-1], v});
        ->chk;
    endtask : expect_out
    task automatic shift(input int n, input bit keep);
        logic b;
        for (int i = 0; i < n; i++) begin
            b = 1'($urandom);
            i_sld_host.send_bit(b);
            if (keep) sr_m = {sr_m[SLD_STAGES-2:0], b};
        end
    endtask : shift
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial begin
        rst_b = 1'b0;
        en = 1'b1;
        sr_m = '0;
        lat_m = '0;
        void'($urandom(32'h105A));
        repeat (10) @(posedge clock);
        #2;
        rst_b = 1'b1;
        i_sld_host.tick(2);
        expect_out(lat_m);
        shift(SLD_STAGES, 1'b1);
        expect_out(lat_m);
        i_sld_host.pins(1'b1, 1'b0);
        i_sld_host.pins(1'b0, 1'b0);
        lat_m = sr_m;
        expect_out(lat_m);
        i_sld_host.pins(1'b0, 1'b1);
        shift(5, 1'b1);
        expect_out('0);
        i_sld_host.pins(1'b0, 1'b0);
        expect_out(lat_m);
        i_sld_host.pins(1'b1, 1'b1);
        lat_m = sr_m;
        shift(8, 1'b1);
        shift(1, 1'b0);
        i_sld_host.pins(1'b0, 1'b0);
        i_sld_host.tick(6);
        expect_out(lat_m);
        check_count++;
        if (ovr != 1) begin
            num_errors++;
            $display("unexpected at %0t: overrun count", $time);
        end
        i_sld_host.pins(1'b1, 1'b0);
        i_sld_host.pins(1'b0, 1'b0);
        lat_m = sr_m;
        expect_out(lat_m);
        // A frozen block misses a whole shift pulse and keeps its outputs
        en = 1'b0;
        shift(1, 1'b0);
        i_sld_host.pins(1'b1, 1'b0);
        i_sld_host.pins(1'b0, 1'b0);
        en = 1'b1;
        i_sld_host.tick(6);
        expect_out(lat_m);
        summarize();
    end
endmodule : tb_sld_driver
